// >>> design/aim_pkg.sv
// constants and types shared by the audio core input mixer files
// assumes one 40 MHz core clock and 24-bit signed audio samples
package aim_pkg;
  localparam int SAMPLE_W = 24;
  localparam int GAIN_W = 7;
  localparam int SRC_W = 8;
  localparam int NUM_INPUTS = 4;
  localparam int NUM_MIX = 4;
  localparam int NUM_SEL = 4;
  localparam int NUM_SRC = 128;
  localparam int NUM_PWM = 2;
  localparam int PWM_W = 8;
  localparam int HAPTIC_W = 16;

  localparam logic [SRC_W-1:0] SRC_SILENCE = 8'h00;
  localparam logic [SRC_W-1:0] SRC_TONE1 = 8'h04;
  localparam logic [SRC_W-1:0] SRC_TONE2 = 8'h05;
  localparam logic [SRC_W-1:0] SRC_HAPTIC = 8'h06;
  localparam logic [SRC_W-1:0] SRC_NOISE = 8'h0D;

  localparam logic [GAIN_W-1:0] GAIN_MIN_CODE = 7'h20;
  localparam logic [GAIN_W-1:0] GAIN_UNITY_CODE = 7'h40;
  localparam logic [GAIN_W-1:0] GAIN_MAX_CODE = 7'h50;
  localparam logic [GAIN_W-1:0] GAIN_IDX_BASE = 7'h1C;
  localparam logic [GAIN_W-1:0] GAIN_DB_PER_SHIFT = 7'h06;
  localparam int GAIN_FRAC_W = 16;
  localparam int GAIN_POST_SHIFT = 20;
  localparam logic [GAIN_FRAC_W-1:0] GAIN_FRAC [6] = '{16'h4000, 16'h47CF, 16'h5092, 16'h5A67, 16'h656F, 16'h71CF};

  localparam int CLK_PERIOD_NS = 25;
  localparam int TONE_FREQ_HZ = 1000;
  localparam int TONE_HALF_NS = 1000000000 / (2 * TONE_FREQ_HZ);
  localparam int TONE_HALF_CYCLES = TONE_HALF_NS / CLK_PERIOD_NS;
  localparam logic signed [SAMPLE_W-1:0] TONE_AMP = 24'h200000;
  localparam logic [SAMPLE_W-1:0] NOISE_SEED = 24'hACE001;
  localparam logic [SAMPLE_W-1:0] NOISE_TAPS = 24'hE10000;
  localparam int NOISE_ATTEN_SHIFT = 4;
  localparam logic [PWM_W-1:0] PWM_WRAP = 8'hFF;

  typedef logic signed [SAMPLE_W-1:0] aim_sample_t;
  typedef enum logic [1:0] {SK_EMPTY = 2'b00, SK_ONE = 2'b01, SK_TWO = 2'b11} aim_skid_state_t;
endpackage

// >>> design/aim_skid2.sv
// two-entry output buffer between a mixer and its receiver
// assumes the receiver may hold outReady low for any time
`timescale 1ns/1ps
`default_nettype none
module aim_skid2
  import aim_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst, // sync reset
  input wire logic inValid, // word offered
  input wire aim_sample_t inData, // word in
  output logic inReady, // room left
  output logic outValid, // head holds a word
  output aim_sample_t outData, // head word
  input wire logic outReady // receiver takes head
);
  typedef struct packed {
    aim_skid_state_t state;
    aim_sample_t head;
    aim_sample_t spare;
  } aim_skid_regs_t;

  aim_skid_regs_t r;
  aim_skid_regs_t next_r;
  logic push;
  logic pop;

  assign inReady = ~r.state[1];
  assign outValid = r.state[0];
  assign outData = r.head;
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_comb
  begin
    next_r = r;
    case (r.state)
      SK_EMPTY:
      begin
        if (push)
        begin
          next_r.head = inData;
          next_r.state = SK_ONE;
        end
      end
      SK_ONE:
      begin
        if (push && pop)
          next_r.head = inData;
        else if (push)
        begin
          next_r.spare = inData;
          next_r.state = SK_TWO;
        end
        else if (pop)
          next_r.state = SK_EMPTY;
      end
      SK_TWO:
      begin
        if (pop)
        begin
          next_r.head = r.spare;
          next_r.state = SK_ONE;
        end
      end
      default: next_r.state = SK_EMPTY;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      r <= '{state: SK_EMPTY, head: '0, spare: '0};
    else
      r <= next_r;
  end
endmodule
`default_nettype wire

// >>> design/aim_mixer4.sv
// one four-input mixer with a gain per input and saturating sum
// assumes inputs already resolved to samples and gated by their status
`timescale 1ns/1ps
`default_nettype none
module aim_mixer4
  import aim_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst, // sync reset
  input wire logic sampleTick, // audio rate strobe
  input wire aim_sample_t [NUM_INPUTS-1:0] inSample, // input samples
  input wire logic [NUM_INPUTS-1:0][GAIN_W-1:0] gainCode, // per input gain
  input wire logic outTaken, // buffer took the result
  output logic outValid, // result pending
  output aim_sample_t outSample // mixed result
);
  localparam int PROD_W = SAMPLE_W + GAIN_FRAC_W + 9;
  localparam int SUM_W = PROD_W + 2;
  localparam int GAIN_STEPS = int'(GAIN_MAX_CODE - GAIN_MIN_CODE) + 1;
  // ten to the power one twentieth, one dB in amplitude
  localparam real DB_STEP = 1.1220184543019633;

  typedef logic [GAIN_STEPS-1:0][SAMPLE_W-1:0] aim_gain_tab_t;

  // exact factor per 1dB step, lowest code first, unity at 2^GAIN_POST_SHIFT
  function automatic aim_gain_tab_t build_gain_tab();
    aim_gain_tab_t t;
    real g;
    t = '0;
    g = real'(1 << GAIN_POST_SHIFT);
    for (int d = 0; d < int'(GAIN_UNITY_CODE - GAIN_MIN_CODE); d++)
      g = g / DB_STEP;
    for (int d = 0; d < GAIN_STEPS; d++)
    begin
      t[d] = SAMPLE_W'($rtoi(g + 0.5));
      g = g * DB_STEP;
    end
    return t;
  endfunction

  localparam aim_gain_tab_t GAIN_TAB = build_gain_tab();

  typedef struct packed {
    logic valid;
    aim_sample_t sample;
  } aim_mix_regs_t;

  aim_mix_regs_t r;
  aim_mix_regs_t next_r;
  logic signed [SUM_W-1:0] sum;

  function automatic logic signed [PROD_W-1:0] apply_gain(input aim_sample_t s, input logic [GAIN_W-1:0] code);
    logic [GAIN_W-1:0] c;
    logic [5:0] idx;
    logic signed [PROD_W-1:0] p;
    c = (code < GAIN_MIN_CODE) ? GAIN_MIN_CODE : ((code > GAIN_MAX_CODE) ? GAIN_MAX_CODE : code);
    idx = 6'(c - GAIN_MIN_CODE);
    p = PROD_W'(s) * $signed(PROD_W'({1'b0, GAIN_TAB[idx]}));
    return p >>> GAIN_POST_SHIFT;
  endfunction

  assign outValid = r.valid;
  assign outSample = r.sample;

  always_comb
  begin
    sum = '0;
    for (int i = 0; i < NUM_INPUTS; i++)
      sum = sum + SUM_W'(apply_gain(inSample[i], gainCode[i]));
    next_r = r;
    if (outTaken)
      next_r.valid = 1'b0;
    if (sampleTick && (!r.valid || outTaken))
    begin
      next_r.valid = 1'b1;
      if (sum > SUM_W'(aim_sample_t'({1'b0, {(SAMPLE_W-1){1'b1}}})))
        next_r.sample = {1'b0, {(SAMPLE_W-1){1'b1}}};
      else if (sum < SUM_W'(aim_sample_t'({1'b1, {(SAMPLE_W-1){1'b0}}})))
        next_r.sample = {1'b1, {(SAMPLE_W-1){1'b0}}};
      else
        next_r.sample = sum[SAMPLE_W-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      r <= '{valid: 1'b0, sample: '0};
    else
      r <= next_r;
  end
endmodule
`default_nettype wire

// >>> design/aim_core.sv
// digital core routing: mixers, source-only selectors and internal generators
// assumes all inputs synchronous to clk and configuration driven by a control block
`timescale 1ns/1ps
`default_nettype none
module aim_core
  import aim_pkg::*;
#(
  parameter int TONE_HALF_CYCLES_P = TONE_HALF_CYCLES
)
(
  input wire logic clk, // core clock, 40 MHz
  input wire logic rst, // sync reset, active high
  input wire logic sampleTick, // audio rate strobe
  input wire logic underclocked, // core clock too slow for request
  input wire aim_sample_t [NUM_SRC-1:0] srcIn, // samples by source code
  input wire logic [NUM_MIX-1:0][NUM_INPUTS-1:0][SRC_W-1:0] inputSourceSelect, // mixer sources
  input wire logic [NUM_MIX-1:0][NUM_INPUTS-1:0][GAIN_W-1:0] inputGainCode, // mixer gains
  output logic [NUM_MIX-1:0][NUM_INPUTS-1:0] inputPathEnabledFlag, // mixer input status
  output aim_sample_t [NUM_MIX-1:0] mixOutSample, // mixer results
  output logic [NUM_MIX-1:0] mixOutValid, // mixer result valid
  input wire logic [NUM_MIX-1:0] mixOutReady, // receiver ready
  input wire logic [NUM_SEL-1:0][SRC_W-1:0] selSourceSelect, // converter and aux sources
  output logic [NUM_SEL-1:0] selPathEnabledFlag, // selector status
  output aim_sample_t [NUM_SEL-1:0] selSample, // selected samples
  output logic [NUM_SEL-1:0] selValid, // selected sample strobe
  input wire logic [1:0] toneEnable, // tone generator enables
  input wire logic noiseEnable, // noise generator enable
  input wire logic hapticEnable, // haptic generator enable
  input wire logic [HAPTIC_W-1:0] hapticHalfPeriod, // haptic half period in clocks, less one
  input wire aim_sample_t hapticAmplitude, // haptic level
  input wire logic [NUM_PWM-1:0][SRC_W-1:0] pwmSourceSelect, // pwm modulation sources
  input wire logic [NUM_PWM-1:0] pwmEnable, // pwm enables
  output logic [NUM_PWM-1:0] pwmOut // pwm pins to gpio
);
  localparam int TONE_CNT_W = $clog2(TONE_HALF_CYCLES_P + 1);
  localparam logic [TONE_CNT_W-1:0] TONE_RELOAD = TONE_CNT_W'(TONE_HALF_CYCLES_P - 1);

  typedef struct packed {
    logic [TONE_CNT_W-1:0] toneCount;
    logic toneLevel;
    logic [SAMPLE_W-1:0] noiseLfsr;
    logic [HAPTIC_W-1:0] hapticCount;
    logic hapticLevel;
    logic [PWM_W-1:0] pwmCount;
    logic [NUM_PWM-1:0][PWM_W-1:0] pwmDuty;
    logic [NUM_PWM-1:0] pwmOut;
    logic [NUM_MIX-1:0][NUM_INPUTS-1:0] mixFlag;
    logic [NUM_SEL-1:0] selFlag;
    aim_sample_t [NUM_SEL-1:0] selSample;
    logic [NUM_SEL-1:0] selValid;
  } aim_core_regs_t;

  aim_core_regs_t r;
  aim_core_regs_t next_r;
  aim_sample_t toneSample;
  aim_sample_t tone1Sample;
  aim_sample_t tone2Sample;
  aim_sample_t noiseSample;
  aim_sample_t hapticSample;
  aim_sample_t [NUM_MIX-1:0][NUM_INPUTS-1:0] mixIn;
  aim_sample_t [NUM_MIX-1:0] mixResult;
  logic [NUM_MIX-1:0] mixResultValid;
  logic [NUM_MIX-1:0] skidReady;
  aim_sample_t [NUM_PWM-1:0] pwmSourceSample;

  function automatic aim_sample_t resolve(input logic [SRC_W-1:0] code, input aim_sample_t t1,
                                          input aim_sample_t t2, input aim_sample_t hap,
                                          input aim_sample_t nz, input aim_sample_t [NUM_SRC-1:0] ext);
    aim_sample_t v;
    v = '0;
    case (code)
      SRC_SILENCE: v = '0;
      SRC_TONE1: v = t1;
      SRC_TONE2: v = t2;
      SRC_HAPTIC: v = hap;
      SRC_NOISE: v = nz;
      default:
      begin
        if (code < SRC_W'(NUM_SRC))
          v = ext[code[$clog2(NUM_SRC)-1:0]];
        else
          v = '0;
      end
    endcase
    return v;
  endfunction

  assign toneSample = r.toneLevel ? TONE_AMP : -TONE_AMP;
  assign tone1Sample = toneEnable[0] ? toneSample : '0;
  assign tone2Sample = toneEnable[1] ? toneSample : '0;
  assign noiseSample = noiseEnable ? (aim_sample_t'(r.noiseLfsr) >>> NOISE_ATTEN_SHIFT) : '0;
  assign hapticSample = hapticEnable ? (r.hapticLevel ? hapticAmplitude : -hapticAmplitude) : '0;

  always_comb
  begin
    for (int m = 0; m < NUM_MIX; m++)
    begin
      for (int i = 0; i < NUM_INPUTS; i++)
      begin
        if (r.mixFlag[m][i])
          mixIn[m][i] = resolve(inputSourceSelect[m][i], tone1Sample, tone2Sample, hapticSample,
                                noiseSample, srcIn);
        else
          mixIn[m][i] = '0;
      end
    end
  end

  always_comb
  begin
    for (int p = 0; p < NUM_PWM; p++)
      pwmSourceSample[p] = resolve(pwmSourceSelect[p], tone1Sample, tone2Sample, hapticSample, noiseSample, srcIn);
  end

  always_comb
  begin
    next_r = r;
    // tone timebase, half period toggle
    if (r.toneCount == '0)
    begin
      next_r.toneCount = TONE_RELOAD;
      next_r.toneLevel = ~r.toneLevel;
    end
    else
      next_r.toneCount = r.toneCount - 1'b1;

    if (sampleTick)
      next_r.noiseLfsr = {r.noiseLfsr[SAMPLE_W-2:0], ^(r.noiseLfsr & NOISE_TAPS)};

    if (!hapticEnable)
    begin
      next_r.hapticCount = '0;
      next_r.hapticLevel = 1'b0;
    end
    else if (r.hapticCount == '0)
    begin
      next_r.hapticCount = hapticHalfPeriod;
      next_r.hapticLevel = ~r.hapticLevel;
    end
    else
      next_r.hapticCount = r.hapticCount - 1'b1;

    next_r.pwmCount = r.pwmCount + 1'b1;
    for (int p = 0; p < NUM_PWM; p++)
    begin
      if (r.pwmCount == PWM_WRAP)
      begin
        next_r.pwmDuty[p] = {~pwmSourceSample[p][SAMPLE_W-1], pwmSourceSample[p][SAMPLE_W-2:SAMPLE_W-PWM_W]};
      end
      next_r.pwmOut[p] = pwmEnable[p] & (r.pwmCount < r.pwmDuty[p]);
    end

    for (int m = 0; m < NUM_MIX; m++)
    begin
      for (int i = 0; i < NUM_INPUTS; i++)
      begin
        if (underclocked)
          next_r.mixFlag[m][i] = r.mixFlag[m][i] & (inputSourceSelect[m][i] != SRC_SILENCE);
        else
          next_r.mixFlag[m][i] = (inputSourceSelect[m][i] != SRC_SILENCE);
      end
    end

    next_r.selValid = '0;
    for (int s = 0; s < NUM_SEL; s++)
    begin
      if (underclocked)
        next_r.selFlag[s] = r.selFlag[s] & (selSourceSelect[s] != SRC_SILENCE);
      else
        next_r.selFlag[s] = (selSourceSelect[s] != SRC_SILENCE);
      if (sampleTick)
      begin
        next_r.selValid[s] = 1'b1;
        if (r.selFlag[s])
          next_r.selSample[s] = resolve(selSourceSelect[s], tone1Sample, tone2Sample, hapticSample,
                                        noiseSample, srcIn);
        else
          next_r.selSample[s] = '0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r <= '0;
      r.toneCount <= TONE_RELOAD;
      r.noiseLfsr <= NOISE_SEED;
    end
    else
      r <= next_r;
  end

  for (genvar m = 0; m < NUM_MIX; m++)
  begin : g_mix
    aim_mixer4 u_mix (
      .clk(clk),
      .rst(rst),
      .sampleTick(sampleTick),
      .inSample(mixIn[m]),
      .gainCode(inputGainCode[m]),
      .outTaken(mixResultValid[m] & skidReady[m]),
      .outValid(mixResultValid[m]),
      .outSample(mixResult[m])
    );

    aim_skid2 u_buf (
      .clk(clk),
      .rst(rst),
      .inValid(mixResultValid[m]),
      .inData(mixResult[m]),
      .inReady(skidReady[m]),
      .outValid(mixOutValid[m]),
      .outData(mixOutSample[m]),
      .outReady(mixOutReady[m])
    );
  end

  assign inputPathEnabledFlag = r.mixFlag;
  assign selPathEnabledFlag = r.selFlag;
  assign selSample = r.selSample;
  assign selValid = r.selValid;
  assign pwmOut = r.pwmOut;
endmodule
`default_nettype wire

// >>> design/unused_placeholder_removed.sv
// intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> testbench/aim_core_monitor.sv
// checker for status flags, selector strobes, mixer buffer and pwm gating
// bound to aim_core; sees only its ports, one clock domain
`timescale 1ns/1ps
`default_nettype none
module aim_core_monitor
  import aim_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst, // sync reset
  input wire logic sampleTick, // audio strobe
  input wire logic underclocked, // clock too slow
  input wire logic [NUM_MIX-1:0][NUM_INPUTS-1:0][SRC_W-1:0] inputSourceSelect, // mixer sources
  input wire logic [NUM_MIX-1:0][NUM_INPUTS-1:0] inputPathEnabledFlag, // mixer status
  input wire aim_sample_t [NUM_MIX-1:0] mixOutSample, // mixer results
  input wire logic [NUM_MIX-1:0] mixOutValid, // result valid
  input wire logic [NUM_MIX-1:0] mixOutReady, // receiver ready
  input wire logic [NUM_SEL-1:0] selValid, // selector strobe
  input wire logic [NUM_PWM-1:0] pwmEnable, // pwm enables
  input wire logic [NUM_PWM-1:0] pwmOut // pwm pins
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence enable_req;
    !underclocked && inputSourceSelect[0][0] != 8'h00;
  endsequence
  sequence stalled_word;
    mixOutValid[0] && !mixOutReady[0];
  endsequence
  sequence fresh_tick;
    sampleTick && !mixOutValid[0] && !$past(sampleTick);
  endsequence
  flag_set_a: assert property (enable_req |=> inputPathEnabledFlag[0][0])
    else $error("flag did not follow enabled source");
  flag_clear_a: assert property (inputSourceSelect[0][0] == 8'h00 |=> !inputPathEnabledFlag[0][0])
    else $error("flag stayed up on silence");
  underclk_refuse_a: assert property (underclocked && !inputPathEnabledFlag[0][0] |=> !inputPathEnabledFlag[0][0])
    else $error("path enabled while underclocked");
  sel_strobe_a: assert property (sampleTick |=> selValid[0])
    else $error("selector strobe missing after tick");
  sel_quiet_a: assert property (!sampleTick |=> !selValid[0])
    else $error("selector strobe without tick");
  buf_hold_a: assert property (stalled_word |=> mixOutValid[0] && $stable(mixOutSample[0]))
    else $error("stalled mixer word changed or dropped");
  mix_latency_a: assert property (fresh_tick |-> ##2 mixOutValid[0])
    else $error("mixer result late");
  pwm_gate_a: assert property (!pwmEnable[0] |=> !pwmOut[0])
    else $error("pwm pin high while disabled");
endmodule
bind aim_core aim_core_monitor aim_core_monitor_inst (.clk, .rst, .sampleTick, .underclocked, .inputSourceSelect,
  .inputPathEnabledFlag, .mixOutSample, .mixOutValid, .mixOutReady, .selValid, .pwmEnable, .pwmOut);
`default_nettype wire

// >>> testbench/aim_sink.sv
// receiver model for one mixer output, able to stall
// assumes words are offered with valid held until ready
`timescale 1ns/1ps
`default_nettype none
module aim_sink
  import aim_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic stall, // hold off taking words
  input wire logic valid, // word offered
  input wire aim_sample_t data, // offered word
  output logic ready // word taken at edge
);
  int unsigned taken;
  aim_sample_t lastWord;
  initial
  begin
    ready = 1'b0;
    taken = 0;
    lastWord = '0;
  end
  // stall is driven on the falling edge, so take it on the rising one
  always @(posedge clk)
    ready <= !stall;
  always @(posedge clk)
    if (valid && ready)
    begin
      taken <= taken + 1;
      lastWord <= data;
    end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the input mixer core
// assumes a short tone half period and one receiver model on mixer 0
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import aim_pkg::*;
  logic clk, rst, sampleTick, underclocked, noiseEnable, hapticEnable, stall, sinkReady;
  aim_sample_t [NUM_SRC-1:0] srcIn;
  logic [NUM_MIX-1:0][NUM_INPUTS-1:0][SRC_W-1:0] inputSourceSelect;
  logic [NUM_MIX-1:0][NUM_INPUTS-1:0][GAIN_W-1:0] inputGainCode;
  logic [NUM_MIX-1:0][NUM_INPUTS-1:0] inputPathEnabledFlag;
  aim_sample_t [NUM_MIX-1:0] mixOutSample;
  logic [NUM_MIX-1:0] mixOutValid, mixOutReady;
  logic [NUM_MIX-2:0] rdyRest;
  logic [NUM_SEL-1:0][SRC_W-1:0] selSourceSelect;
  logic [NUM_SEL-1:0] selPathEnabledFlag, selValid;
  aim_sample_t [NUM_SEL-1:0] selSample;
  logic [1:0] toneEnable;
  logic [HAPTIC_W-1:0] hapticHalfPeriod;
  aim_sample_t hapticAmplitude;
  logic [NUM_PWM-1:0][SRC_W-1:0] pwmSourceSelect;
  logic [NUM_PWM-1:0] pwmEnable, pwmOut;
  int miscompares = 0;
  int testsRun = 0;
  assign mixOutReady = {rdyRest, sinkReady};
  aim_core #(.TONE_HALF_CYCLES_P(8)) aim_core_inst (.clk, .rst, .sampleTick, .underclocked, .srcIn,
    .inputSourceSelect, .inputGainCode, .inputPathEnabledFlag, .mixOutSample, .mixOutValid, .mixOutReady,
    .selSourceSelect, .selPathEnabledFlag, .selSample, .selValid, .toneEnable, .noiseEnable, .hapticEnable,
    .hapticHalfPeriod, .hapticAmplitude, .pwmSourceSelect, .pwmEnable, .pwmOut);
  aim_sink aim_sink_inst (.clk, .stall, .valid(mixOutValid[0]), .data(mixOutSample[0]), .ready(sinkReady));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tick();
    @(negedge clk);
    sampleTick = 1'b1;
    @(negedge clk);
    sampleTick = 1'b0;
  endtask
  task automatic chk_s(input aim_sample_t got, input aim_sample_t exp, input string msg);
    testsRun++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp, input string msg);
    testsRun++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %0t %s got %b", $time, msg, got);
    end
  endtask
  task automatic chk_g(input aim_sample_t got, input real exp, input string msg);
    real d;
    real tol;
    d = got - exp;
    tol = (exp < 0.0 ? -exp : exp) / 1024.0 + 4.0;
    testsRun++;
    if ($isunknown(got) || d > tol || d < -tol)
    begin
      miscompares++;
      $display("FAIL %0t %s got %h exp %f", $time, msg, got, exp);
    end
  endtask
  task automatic close_out();
    if (miscompares == 0 && testsRun > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_reset();
    chk_b(|inputPathEnabledFlag, 1'b0, "flags after reset");
    chk_b(|{mixOutValid, selValid, pwmOut}, 1'b0, "outputs after reset");
  endtask
  task automatic t_flags();
    inputSourceSelect[0][0] = 8'h10;
    step(2);
    chk_b(inputPathEnabledFlag[0][0], 1'b1, "flag on enable");
    underclocked = 1'b1;
    inputSourceSelect[1][0] = 8'h11;
    step(3);
    chk_b(inputPathEnabledFlag[1][0], 1'b0, "enable while underclocked");
    chk_b(inputPathEnabledFlag[0][0], 1'b1, "kept path while underclocked");
    inputSourceSelect[0][0] = 8'h00;
    step(2);
    chk_b(inputPathEnabledFlag[0][0], 1'b0, "disable while underclocked");
    underclocked = 1'b0;
    step(2);
    chk_b(inputPathEnabledFlag[1][0], 1'b1, "enable after recovery");
    inputSourceSelect[1][0] = 8'h00;
  endtask
  task automatic t_gain();
    logic [GAIN_W-1:0] codes [7] = '{7'h00, 7'h20, 7'h21, 7'h40, 7'h4F, 7'h50, 7'h7F};
    int dbs [7] = '{-32, -32, -31, 0, 15, 16, 16};
    inputSourceSelect[0][0] = 8'h10;
    srcIn[16] = 24'h100000;
    for (int i = 0; i < 7; i++)
    begin
      inputGainCode[0][0] = codes[i];
      step(2);
      tick();
      step(6);
      chk_g(aim_sink_inst.lastWord, 1048576.0 * (10.0 ** (dbs[i] / 20.0)), "gain step");
    end
  endtask
  task automatic t_sat();
    inputSourceSelect[0] = {4{8'h10}};
    inputSourceSelect[3] = {4{8'h10}};
    inputGainCode[0] = {4{7'h40}};
    inputGainCode[3] = {4{7'h40}};
    rdyRest[2] = 1'b0;
    srcIn[16] = 24'h300000;
    step(2);
    tick();
    step(6);
    chk_s(aim_sink_inst.lastWord, 24'h7FFFFF, "positive clip");
    chk_b(mixOutValid[3], 1'b1, "second mixer valid");
    chk_s(mixOutSample[3], 24'h7FFFFF, "second mixer same result");
    rdyRest[2] = 1'b1;
    srcIn[16] = 24'hD00000;
    step(2);
    tick();
    step(6);
    chk_s(aim_sink_inst.lastWord, 24'h800000, "negative clip");
  endtask
  task automatic t_stall();
    int unsigned n0;
    stall = 1'b1;
    step(2);
    n0 = aim_sink_inst.taken;
    repeat (5)
    begin
      tick();
      step(1);
    end
    chk_b(mixOutValid[0], 1'b1, "word held during stall");
    stall = 1'b0;
    step(12);
    chk_b(aim_sink_inst.taken - n0 == 3, 1'b1, "buffered words delivered");
  endtask
  task automatic t_gen();
    toneEnable = 2'b11;
    noiseEnable = 1'b1;
    hapticEnable = 1'b1;
    hapticAmplitude = 24'h123456;
    selSourceSelect = {SRC_NOISE, SRC_HAPTIC, SRC_TONE2, SRC_TONE1};
    step(2);
    tick();
    chk_b(selSample[0] == TONE_AMP || selSample[0] == -TONE_AMP, 1'b1, "tone one level");
    chk_b(selSample[1] == TONE_AMP || selSample[1] == -TONE_AMP, 1'b1, "tone two level");
    chk_b(selSample[2] == 24'h123456 || selSample[2] == 24'hEDCBAA, 1'b1, "haptic level");
    chk_b(selSample[3] != 0 && selSample[3] < 24'sh080000 && selSample[3] >= -24'sh080000, 1'b1, "noise");
    toneEnable = 2'b00;
    noiseEnable = 1'b0;
    selSourceSelect = {SRC_NOISE, 8'h10, SRC_TONE2, SRC_SILENCE};
    step(2);
    tick();
    chk_b(selPathEnabledFlag[0], 1'b0, "silence flag");
    chk_b(selPathEnabledFlag[2], 1'b1, "selector flag");
    chk_s(selSample[0], 24'h000000, "silence");
    chk_s(selSample[1], 24'h000000, "tone off");
    chk_s(selSample[2], srcIn[16], "external source");
    chk_s(selSample[3], 24'h000000, "noise off");
  endtask
  task automatic t_pwm();
    aim_sample_t vals [3] = '{24'h000000, 24'h7FFFFF, 24'h800000};
    int highs [3] = '{256, 510, 0};
    int cnt;
    pwmSourceSelect = {8'h10, 8'h10};
    pwmEnable = 2'b11;
    for (int i = 0; i < 3; i++)
    begin
      srcIn[16] = vals[i];
      step(300);
      cnt = 0;
      repeat (256)
      begin
        @(negedge clk);
        cnt += pwmOut[0] + pwmOut[1];
      end
      chk_b(cnt == highs[i], 1'b1, "pwm duty");
    end
  endtask
  initial
  begin
    rst = 1'b1;
    sampleTick = 1'b0;
    underclocked = 1'b0;
    stall = 1'b0;
    rdyRest = '1;
    srcIn = '0;
    inputSourceSelect = '0;
    inputGainCode = {16{7'h40}};
    selSourceSelect = '0;
    toneEnable = 2'b00;
    noiseEnable = 1'b0;
    hapticEnable = 1'b0;
    hapticHalfPeriod = 16'h0003;
    hapticAmplitude = '0;
    pwmSourceSelect = '0;
    pwmEnable = '0;
    step(10);
    rst = 1'b0;
    step(1);
    t_reset();
    t_flags();
    t_gain();
    t_sat();
    t_stall();
    t_gen();
    t_pwm();
    close_out();
  end
  initial
  begin
    #(25 * 20000);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
